/* logic/usbsr_device.sv */
// device end: suspend/resume, remote wakeup, ep0 flags, ep1 event
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module usbsr_device #(
   parameter int SUSP_CYC = usbsr_pkg::SUSPEND_CYC,
   parameter int WAIT_CYC = usbsr_pkg::WAKE_WAIT_CYC
) (
   input  wire logic       clk_sys_in,
   input  wire logic       sys_rst_in,
   input  wire logic       power_rst_in,
   usbsr_link_if.dev       link,
   input  wire logic [1:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic [7:0]      reg_rdata_out,
   output logic            irq_out,
   output logic            suspended_out
);
   typedef struct packed {
      usbsr_pkg::usbsr_dev_st_t    st;
      logic [usbsr_pkg::CNT_W-1:0] cnt;
      logic                        wake;
      logic                        stall;
      logic                        pull;
      logic                        first;
      logic [usbsr_pkg::IRQ_W-1:0] istat;
      logic [usbsr_pkg::IRQ_W-1:0] imask;
      logic [7:0]                  rdata;
      logic                        irq;
      logic                        drvk;
      logic                        susp;
      logic                        hv;
      logic [1:0]                  hc;
   } usbsr_dev_t;

   localparam usbsr_dev_t RST = '{st: usbsr_pkg::DEV_ACTIVE, default: '0};

   usbsr_dev_t s_q;
   usbsr_dev_t s_d;

   logic                        wr_ctrl;
   logic                        wr_istat;
   logic                        wr_imask;
   logic                        setup_ep0;
   logic                        stall_hit;
   logic                        tok_ep0;
   logic                        rx_ev;
   logic                        tx_ev;
   logic                        ep1_ev;
   logic                        idle;
   logic [usbsr_pkg::IRQ_W-1:0] ev;

   always_comb begin
      s_d     = s_q;
      s_d.hv  = 1'b0;
      s_d.hc  = usbsr_pkg::HS_ACK;
      s_d.cnt = s_q.cnt + 1'b1;
      wr_ctrl = reg_wr_in && reg_addr_in == usbsr_pkg::REG_CTRL;
      wr_istat = reg_wr_in && reg_addr_in == usbsr_pkg::REG_ISTAT;
      wr_imask = reg_wr_in && reg_addr_in == usbsr_pkg::REG_IMASK;
      tok_ep0 = link.tok_valid && link.tok_ep == usbsr_pkg::EP_ZERO;
      setup_ep0 = tok_ep0 && link.tok_pid == usbsr_pkg::PID_SETUP;
      // judged on the old bit, so a same-cycle write waits a token
      stall_hit = tok_ep0 && link.tok_pid == usbsr_pkg::PID_OUT && s_q.stall;
      rx_ev   = tok_ep0 && (link.tok_pid == usbsr_pkg::PID_SETUP ||
                (link.tok_pid == usbsr_pkg::PID_OUT && !s_q.stall));
      tx_ev   = tok_ep0 && link.tok_pid == usbsr_pkg::PID_IN;
      ep1_ev  = link.tok_valid && link.tok_ep == usbsr_pkg::EP_ONE &&
                link.tok_pid == usbsr_pkg::PID_IN;
      idle    = link.line == usbsr_pkg::LINE_J && !link.tok_valid;
      ev      = '0;

      // firmware writes first, hardware events below win over them
      if (wr_ctrl) begin
         s_d.wake  = reg_wdata_in[usbsr_pkg::CTRL_WAKE];
         s_d.stall = reg_wdata_in[usbsr_pkg::CTRL_STALL];
         s_d.pull  = reg_wdata_in[usbsr_pkg::CTRL_PULL];
         if (reg_wdata_in[usbsr_pkg::CTRL_CLR1]) begin
            s_d.first = 1'b0;
         end
      end

      if (wr_istat) begin
         s_d.istat = s_q.istat & ~reg_wdata_in[usbsr_pkg::IRQ_W-1:0];
      end
      if (wr_imask) begin
         s_d.imask = reg_wdata_in[usbsr_pkg::IRQ_W-1:0];
      end

      // token handling; answers land one cycle after the token
      if (setup_ep0) begin
         s_d.stall = 1'b0;
      end
      if (stall_hit) begin
         s_d.hv = 1'b1;
         s_d.hc = usbsr_pkg::HS_STALL;
      end else if (link.tok_valid && link.tok_pid != usbsr_pkg::PID_SOF) begin
         s_d.hv = 1'b1;
      end
      if (rx_ev && (s_q.istat[usbsr_pkg::IRQ_EP0TX] || tx_ev)) begin
         s_d.first = 1'b1;
      end

      // sticky bits: events are or-ed in after any clear
      ev[usbsr_pkg::IRQ_EP0RX] = rx_ev;
      ev[usbsr_pkg::IRQ_EP0TX] = tx_ev;
      ev[usbsr_pkg::IRQ_EP1TX] = ep1_ev;

      // own K is not bus activity, so it never wakes us by itself
      unique case (s_q.st)
         usbsr_pkg::DEV_ACTIVE: begin
            // only J with no token counts; anything else restarts
            if (!idle || s_q.drvk) begin
               s_d.cnt = '0;
            end else if (s_q.cnt == usbsr_pkg::CNT_W'(SUSP_CYC - 1)) begin
               s_d.st = usbsr_pkg::DEV_SUSPEND;
               ev[usbsr_pkg::IRQ_SUSP] = 1'b1;
            end
         end

         usbsr_pkg::DEV_SUSPEND: begin
            s_d.cnt = '0;
            // SE0 reads as a bus reset only with the pull-up attached
            if (link.tok_valid || (!s_q.drvk &&
                link.line == usbsr_pkg::LINE_SE0 && s_q.pull)) begin
               s_d.st = usbsr_pkg::DEV_ACTIVE;
               ev[usbsr_pkg::IRQ_RESUM] = 1'b1;
            end else if (!s_q.drvk && link.line == usbsr_pkg::LINE_K) begin
               s_d.st = usbsr_pkg::DEV_RESUMING;
            end else if (s_q.drvk && !s_d.wake) begin
               s_d.st = usbsr_pkg::DEV_WAKEWAIT;
               ev[usbsr_pkg::IRQ_RESUM] = 1'b1;
            end
         end

         usbsr_pkg::DEV_RESUMING: begin
            s_d.cnt = '0;
            // the eop ends the host's K; back at J we await traffic
            if (link.line == usbsr_pkg::LINE_J) begin
               s_d.st = usbsr_pkg::DEV_WAKEWAIT;
               ev[usbsr_pkg::IRQ_RESUM] = 1'b1;
            end
         end

         usbsr_pkg::DEV_WAKEWAIT: begin
            // a bare keep-alive is traffic enough
            if (link.tok_valid) begin
               s_d.st  = usbsr_pkg::DEV_ACTIVE;
               s_d.cnt = '0;
            end else if (s_q.cnt == usbsr_pkg::CNT_W'(WAIT_CYC - 1)) begin
               s_d.st = usbsr_pkg::DEV_SUSPEND;
               ev[usbsr_pkg::IRQ_SUSP] = 1'b1;
            end
         end
         // an illegal code falls back to awake, the safe side
         default: s_d.st = usbsr_pkg::DEV_ACTIVE;
      endcase

      // K follows the bit; the interval is firmware's to time
      s_d.drvk  = s_d.wake;
      s_d.istat = s_d.istat | ev;

      // zero outside the read cycle keeps stale data off the port
      unique case (reg_addr_in)
         usbsr_pkg::REG_CTRL: s_d.rdata = {5'h00, s_q.pull, s_q.stall,
                                           s_q.wake};
         usbsr_pkg::REG_STATUS: s_d.rdata = {5'h00, s_q.drvk,
            s_q.st == usbsr_pkg::DEV_SUSPEND, s_q.first};
         usbsr_pkg::REG_ISTAT: s_d.rdata = {3'h0, s_q.istat};
         usbsr_pkg::REG_IMASK: s_d.rdata = {3'h0, s_q.imask};
      endcase
      if (!reg_rd_in) begin
         s_d.rdata = 8'h00;
      end

      // a plain reset keeps the pull-up; only power loss drops it
      if (sys_rst_in || power_rst_in) begin
         s_d      = RST;
         s_d.pull = power_rst_in ? 1'b0 : s_q.pull;
      end
      s_d.irq = |(s_d.istat & s_d.imask);
      // decoded from the next state so the pin is a plain flop
      s_d.susp = s_d.st == usbsr_pkg::DEV_SUSPEND;
   end

   always_ff @(posedge clk_sys_in) begin
      s_q <= s_d;
   end

   assign link.dev_oe     = s_q.drvk;
   assign link.dev_line   = usbsr_pkg::LINE_K;
   assign link.dev_pullup = s_q.pull;
   assign link.hs_valid   = s_q.hv;
   assign link.hs_code    = s_q.hc;
   assign reg_rdata_out   = s_q.rdata;
   assign irq_out         = s_q.irq;
   assign suspended_out   = s_q.susp;
endmodule : usbsr_device

/* logic/usbsr_host.sv */
// host end: resume, bus reset, keep-alive and token issue
`timescale 1ns/100ps
module usbsr_host #(
   parameter int RESUME_CYC = usbsr_pkg::RESUME_K_CYC,
   parameter int RESET_CYC  = usbsr_pkg::BUS_RESET_CYC
) (
   input  wire logic       clk_sys_in,
   input  wire logic       sys_rst_in,
   usbsr_link_if.host      link,
   input  wire logic       cmd_resume_in,
   input  wire logic       cmd_reset_in,
   input  wire logic       cmd_token_in,
   input  wire logic [1:0] cmd_pid_in,
   input  wire logic [1:0] cmd_ep_in,
   output logic            busy_out,
   output logic            wake_seen_out,
   output logic            hs_valid_out,
   output logic [1:0]      hs_code_out
);
   typedef struct packed {
      usbsr_pkg::usbsr_hst_st_t st;
      logic [usbsr_pkg::CNT_W-1:0] cnt;
      logic                        oe;
      logic [1:0]                  line;
      logic                        tv;
      logic [1:0]                  pid;
      logic [1:0]                  ep;
      logic                        wake;
      logic                        hv;
      logic [1:0]                  hc;
      logic                        busy;
   } usbsr_hst_t;

   localparam usbsr_hst_t RST = '{st: usbsr_pkg::HST_IDLE,
      line: usbsr_pkg::LINE_J, default: '0};

   usbsr_hst_t s_q;
   usbsr_hst_t s_d;

   always_comb begin
      s_d     = s_q;
      s_d.tv  = 1'b0;
      s_d.hv  = link.hs_valid;
      s_d.hc  = link.hs_code;
      s_d.cnt = s_q.cnt + 1'b1;
      unique case (s_q.st)
         usbsr_pkg::HST_IDLE: begin
            // device-driven K while we are quiet is a remote wakeup
            if (!s_q.oe && link.line == usbsr_pkg::LINE_K) begin
               s_d.wake = 1'b1;
            end
            s_d.cnt = '0;
            if (cmd_resume_in) begin
               s_d.st   = usbsr_pkg::HST_RESUME;
               s_d.oe   = 1'b1;
               s_d.line = usbsr_pkg::LINE_K;
               s_d.wake = 1'b0;
            end else if (cmd_reset_in) begin
               s_d.st   = usbsr_pkg::HST_RESET;
               s_d.oe   = 1'b1;
               s_d.line = usbsr_pkg::LINE_SE0;
            end else if (cmd_token_in) begin
               s_d.tv  = 1'b1;
               s_d.pid = cmd_pid_in;
               s_d.ep  = cmd_ep_in;
            end
         end
         usbsr_pkg::HST_RESUME: begin
            if (s_q.cnt == usbsr_pkg::CNT_W'(RESUME_CYC - 1)) begin
               s_d.st   = usbsr_pkg::HST_EOP;
               s_d.line = usbsr_pkg::LINE_SE0;
               s_d.cnt  = '0;
            end
         end
         usbsr_pkg::HST_EOP: begin
            if (s_q.cnt == usbsr_pkg::CNT_W'(usbsr_pkg::EOP_CYC - 1)) begin
               s_d.st   = usbsr_pkg::HST_KEEP;
               s_d.oe   = 1'b0;
               s_d.line = usbsr_pkg::LINE_J;
            end
         end
         usbsr_pkg::HST_RESET: begin
            if (s_q.cnt == usbsr_pkg::CNT_W'(RESET_CYC - 1)) begin
               s_d.st   = usbsr_pkg::HST_IDLE;
               s_d.oe   = 1'b0;
               s_d.line = usbsr_pkg::LINE_J;
               s_d.wake = 1'b0;
            end
         end
         usbsr_pkg::HST_KEEP: begin
            // traffic right after the eop keeps the device awake
            s_d.tv  = 1'b1;
            s_d.pid = usbsr_pkg::PID_SOF;
            s_d.ep  = usbsr_pkg::EP_ZERO;
            s_d.st  = usbsr_pkg::HST_IDLE;
         end
         default: s_d = RST;
      endcase
      if (sys_rst_in) begin
         s_d = RST;
      end
      s_d.busy = s_d.st != usbsr_pkg::HST_IDLE;
   end

   always_ff @(posedge clk_sys_in) begin
      s_q <= s_d;
   end

   assign link.host_oe   = s_q.oe;
   assign link.host_line = s_q.line;
   assign link.tok_valid = s_q.tv;
   assign link.tok_pid   = s_q.pid;
   assign link.tok_ep    = s_q.ep;
   assign busy_out       = s_q.busy;
   assign wake_seen_out  = s_q.wake;
   assign hs_valid_out   = s_q.hv;
   assign hs_code_out    = s_q.hc;
endmodule : usbsr_host

/* logic/usbsr_link_if.sv */
// link between the usb device end and the host end
`timescale 1ns/100ps
interface usbsr_link_if;
   logic       host_oe;
   logic [1:0] host_line;
   logic       dev_oe;
   logic [1:0] dev_line;
   logic       dev_pullup;
   logic       tok_valid;
   logic [1:0] tok_pid;
   logic [1:0] tok_ep;
   logic       hs_valid;
   logic [1:0] hs_code;
   logic [1:0] line;

   // resolved line: any driver wins over the pull-up, else detached is SE0
   assign line = dev_oe ? dev_line :
                 host_oe ? host_line :
                 dev_pullup ? usbsr_pkg::LINE_J : usbsr_pkg::LINE_SE0;

   modport dev (
      input  line, tok_valid, tok_pid, tok_ep,
      output dev_oe, dev_line, dev_pullup, hs_valid, hs_code
   );
   modport host (
      input  line, hs_valid, hs_code,
      output host_oe, host_line, tok_valid, tok_pid, tok_ep
   );
endinterface : usbsr_link_if

/* logic/usbsr_pkg.sv */
// shared constants and types for the usb suspend/resume link
package usbsr_pkg;
   // bus line symbols as seen on the resolved data-line pair
   localparam logic [1:0] LINE_SE0 = 2'h0;
   localparam logic [1:0] LINE_J   = 2'h1;
   localparam logic [1:0] LINE_K   = 2'h2;
   // token identifiers
   localparam logic [1:0] PID_OUT   = 2'h0;
   localparam logic [1:0] PID_IN    = 2'h1;
   localparam logic [1:0] PID_SETUP = 2'h2;
   localparam logic [1:0] PID_SOF   = 2'h3;
   // handshake codes
   localparam logic [1:0] HS_ACK   = 2'h0;
   localparam logic [1:0] HS_NAK   = 2'h1;
   localparam logic [1:0] HS_STALL = 2'h2;
   // endpoint numbers
   localparam logic [1:0] EP_ZERO = 2'h0;
   localparam logic [1:0] EP_ONE  = 2'h1;
   // timing, printed figures and derived counts at the system clock
   localparam int CLK_MHZ       = 100;
   localparam int SUSPEND_US    = 3000;
   localparam int WAKE_WAIT_US  = 3000;
   localparam int RESUME_K_US   = 20000;
   localparam int BUS_RESET_US  = 10000;
   localparam int EOP_NS        = 1333;
   localparam int SUSPEND_CYC   = SUSPEND_US * CLK_MHZ;
   localparam int WAKE_WAIT_CYC = WAKE_WAIT_US * CLK_MHZ;
   localparam int RESUME_K_CYC  = RESUME_K_US * CLK_MHZ;
   localparam int BUS_RESET_CYC = BUS_RESET_US * CLK_MHZ;
   localparam int EOP_CYC       = (EOP_NS * CLK_MHZ) / 1000;
   localparam int CNT_W         = 24;
   // register indices on the firmware port
   localparam logic [1:0] REG_CTRL   = 2'h0;
   localparam logic [1:0] REG_STATUS = 2'h1;
   localparam logic [1:0] REG_ISTAT  = 2'h2;
   localparam logic [1:0] REG_IMASK  = 2'h3;
   // control register fields
   localparam int CTRL_WAKE  = 0;
   localparam int CTRL_STALL = 1;
   localparam int CTRL_PULL  = 2;
   localparam int CTRL_CLR1  = 3;
   // status register fields
   localparam int STAT_FIRST = 0;
   localparam int STAT_SUSP  = 1;
   localparam int STAT_DRVK  = 2;
   // interrupt status fields
   localparam int IRQ_EP0RX = 0;
   localparam int IRQ_EP0TX = 1;
   localparam int IRQ_EP1TX = 2;
   localparam int IRQ_RESUM = 3;
   localparam int IRQ_SUSP  = 4;
   localparam int IRQ_W     = 5;

   typedef enum logic [3:0] {
      DEV_ACTIVE   = 4'h1,
      DEV_SUSPEND  = 4'h2,
      DEV_RESUMING = 4'h4,
      DEV_WAKEWAIT = 4'h8
   } usbsr_dev_st_t;

   typedef enum logic [4:0] {
      HST_IDLE   = 5'h01,
      HST_RESUME = 5'h02,
      HST_EOP    = 5'h04,
      HST_RESET  = 5'h08,
      HST_KEEP   = 5'h10
   } usbsr_hst_st_t;
endpackage : usbsr_pkg

/* tb/usb_suspend_resume_ep_flags_tb.sv */
// self-checking bench: host and device ends joined by the link
`timescale 1ns/100ps
module usb_suspend_resume_ep_flags_tb;
   logic       clk_sys_in   = 1'b0;
   logic       sys_rst_in   = 1'b1;
   logic       power_rst_in = 1'b1;
   logic       c_res = 1'b0, c_rst = 1'b0, c_tok = 1'b0;
   logic [1:0] c_pid = 2'h0, c_ep = 2'h0, r_a = 2'h0, hsc, hs_q = 2'h3;
   logic [7:0] r_wd = 8'h00, r_q;
   logic       r_wr = 1'b0, r_rd = 1'b0, irq, susp, busy, wake, hsv;
   logic [8:0] row;
   int         n_errors = 0, tests_run = 0, cyc = 0;
   // rows: token id, endpoint, expected interrupt status
   localparam logic [8:0] ROWS [5] = '{{2'h1, 2'h0, 5'h02},
      {2'h0, 2'h0, 5'h01}, {2'h2, 2'h0, 5'h01}, {2'h1, 2'h1, 5'h04},
      {2'h0, 2'h1, 5'h00}};

   usbsr_link_if link ();
   usbsr_host #(.RESUME_CYC(40), .RESET_CYC(20)) usbsr_host_i (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .link(link),
      .cmd_resume_in(c_res), .cmd_reset_in(c_rst), .cmd_token_in(c_tok),
      .cmd_pid_in(c_pid), .cmd_ep_in(c_ep), .busy_out(busy),
      .wake_seen_out(wake), .hs_valid_out(hsv), .hs_code_out(hsc));
   usbsr_device #(.SUSP_CYC(50), .WAIT_CYC(50)) usbsr_device_i (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .power_rst_in(power_rst_in), .link(link), .reg_addr_in(r_a),
      .reg_wdata_in(r_wd), .reg_wr_in(r_wr), .reg_rd_in(r_rd),
      .reg_rdata_out(r_q), .irq_out(irq), .suspended_out(susp));
   // checker defaults match the short host timings above
   usbsr_link_sva usbsr_link_sva_i (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .host_oe(link.host_oe), .host_line(link.host_line),
      .dev_oe(link.dev_oe), .dev_line(link.dev_line),
      .tok_valid(link.tok_valid), .tok_pid(link.tok_pid),
      .tok_ep(link.tok_ep), .hs_valid(link.hs_valid),
      .hs_code(link.hs_code), .line(link.line));

   always #5 clk_sys_in = ~clk_sys_in;

   // handshake seen by the host; about 510 cycles expected, cut at 3000
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (hsv) hs_q <= hsc;
      if (cyc == 3000) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      r_a <= a;
      r_wd <= d;
      r_wr <= 1'b1;
      @(posedge clk_sys_in);
      r_wr <= 1'b0;
      @(posedge clk_sys_in);
   endtask : wr

   // data stand only in the cycle after the strobe
   task automatic rc(input logic [1:0] a, input logic [7:0] e,
                     input string n);
      r_a <= a;
      r_rd <= 1'b1;
      @(posedge clk_sys_in);
      r_rd <= 1'b0;
      #1 chk(n, e, r_q);
      @(posedge clk_sys_in);
   endtask : rc

   // code 3 is no handshake, so a missing answer cannot pass as stale
   task automatic tok(input logic [1:0] p, input logic [1:0] e);
      c_pid <= p;
      c_ep <= e;
      c_tok <= 1'b1;
      hs_q <= 2'h3;
      @(posedge clk_sys_in);
      c_tok <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
   endtask : tok

   task automatic hostcmd(input logic rs);
      if (rs) c_res <= 1'b1;
      else c_rst <= 1'b1;
      @(posedge clk_sys_in);
      c_res <= 1'b0;
      c_rst <= 1'b0;
      @(posedge clk_sys_in);
      for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
         @(posedge clk_sys_in);
         #1;
      end
      repeat (4) @(posedge clk_sys_in);
   endtask : hostcmd

   task automatic wait_susp(input int n);
      for (int i = 0; i < n && susp !== 1'b1; i++) begin
         @(posedge clk_sys_in);
         #1;
      end
   endtask : wait_susp

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (5) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      power_rst_in <= 1'b0;
      @(posedge clk_sys_in);
      wr(2'h3, 8'h1F);
      wr(2'h0, 8'h04);
      for (int i = 0; i < 5; i++) begin
         row = ROWS[i];
         tok(row[8:7], row[6:5]);
         #1 chk("handshake", 8'h00, {6'h00, hs_q});
         rc(2'h2, {3'h0, row[4:0]}, "istat");
         #1 chk("irq", {7'h00, |row[4:0]}, {7'h00, irq});
         wr(2'h2, 8'h1F);
      end
      rc(2'h1, 8'h00, "first flag");
      $display("test rows done");
      sys_rst_in <= 1'b1;
      @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_sys_in);
      rc(2'h0, 8'h04, "ctrl");
      rc(2'h2, 8'h00, "istat");
      rc(2'h3, 8'h00, "imask");
      power_rst_in <= 1'b1;
      @(posedge clk_sys_in);
      power_rst_in <= 1'b0;
      @(posedge clk_sys_in);
      rc(2'h0, 8'h00, "ctrl");
      #1 chk("pullup", 8'h00, {7'h00, link.dev_pullup});
      wr(2'h3, 8'h1F);
      wr(2'h0, 8'h04);
      $display("test reset done");
      tok(2'h1, 2'h0);
      tok(2'h0, 2'h0);
      rc(2'h1, 8'h01, "first flag");
      wr(2'h0, 8'h04);
      rc(2'h1, 8'h01, "first flag");
      wr(2'h0, 8'h0C);
      rc(2'h1, 8'h00, "first flag");
      rc(2'h0, 8'h04, "ctrl");
      wr(2'h2, 8'h1F);
      $display("test first flag done");
      wr(2'h0, 8'h06);
      tok(2'h0, 2'h0);
      #1 chk("handshake", 8'h02, {6'h00, hs_q});
      rc(2'h2, 8'h00, "istat");
      tok(2'h2, 2'h0);
      #1 chk("handshake", 8'h00, {6'h00, hs_q});
      rc(2'h0, 8'h04, "ctrl");
      wr(2'h3, 8'h00);
      #1 chk("irq masked", 8'h00, {7'h00, irq});
      wr(2'h3, 8'h1F);
      wr(2'h2, 8'h1F);
      $display("test stall done");
      repeat (30) @(posedge clk_sys_in);
      #1 chk("suspended", 8'h00, {7'h00, susp});
      wait_susp(40);
      chk("suspended", 8'h01, {7'h00, susp});
      rc(2'h2, 8'h10, "istat");
      wr(2'h2, 8'h1F);
      hostcmd(1'b1);
      #1 chk("suspended", 8'h00, {7'h00, susp});
      rc(2'h2, 8'h08, "istat");
      $display("test host resume done");
      wait_susp(80);
      wr(2'h2, 8'h1F);
      wr(2'h0, 8'h05);
      repeat (3) @(posedge clk_sys_in);
      #1 chk("line", 8'h02, {6'h00, link.line});
      chk("wake seen", 8'h01, {7'h00, wake});
      rc(2'h1, 8'h06, "status");
      repeat (20) @(posedge clk_sys_in);
      wr(2'h0, 8'h04);
      repeat (3) @(posedge clk_sys_in);
      #1 chk("line", 8'h01, {6'h00, link.line});
      chk("suspended", 8'h00, {7'h00, susp});
      rc(2'h2, 8'h08, "istat");
      repeat (30) @(posedge clk_sys_in);
      #1 chk("suspended", 8'h00, {7'h00, susp});
      wait_susp(40);
      chk("suspended", 8'h01, {7'h00, susp});
      $display("test remote wakeup done");
      wr(2'h2, 8'h1F);
      hostcmd(1'b0);
      #1 chk("suspended", 8'h00, {7'h00, susp});
      chk("wake seen", 8'h00, {7'h00, wake});
      rc(2'h2, 8'h08, "istat");
      $display("test bus reset done");
      report_and_stop();
   end
endmodule : usb_suspend_resume_ep_flags_tb

/* tb/usbsr_link_sva.sv */
// assertion checker on the signals of the device/host link
`timescale 1ns/100ps
module usbsr_link_sva #(
   parameter int RESUME_CYC = 40,
   parameter int RESET_CYC  = 20
) (
   input wire logic       clk_sys_in,
   input wire logic       sys_rst_in,
   input wire logic       host_oe,
   input wire logic [1:0] host_line,
   input wire logic       dev_oe,
   input wire logic [1:0] dev_line,
   input wire logic       tok_valid,
   input wire logic [1:0] tok_pid,
   input wire logic [1:0] tok_ep,
   input wire logic       hs_valid,
   input wire logic [1:0] hs_code,
   input wire logic [1:0] line
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);

   // run lengths of host K and host SE0; the figures are too long to repeat
   logic [23:0] k_run_q;
   logic [23:0] z_run_q;
   wire         host_k = host_oe && host_line == 2'h2;
   wire         host_z = host_oe && host_line == 2'h0;
   always_ff @(posedge clk_sys_in) begin
      k_run_q <= (sys_rst_in || !host_k) ? 24'h0 : k_run_q + 24'h1;
      z_run_q <= (sys_rst_in || !host_z) ? 24'h0 : z_run_q + 24'h1;
   end

   sequence s_k_end;
      k_run_q != 24'h0 && !host_k;
   endsequence
   sequence s_eop_end;
      z_run_q == 24'h85 && !host_z;
   endsequence
   sequence s_in_ep1;
      tok_valid && tok_pid == 2'h1 && tok_ep == 2'h1;
   endsequence

   property p_resume_len;
      s_k_end |-> k_run_q == 24'(RESUME_CYC) && host_z;
   endproperty
   property p_se0_len;
      z_run_q != 24'h0 && !host_z |->
         z_run_q == 24'h85 || z_run_q == 24'(RESET_CYC);
   endproperty
   property p_sof_after;
      s_eop_end |-> ##[0:2] (tok_valid && tok_pid == 2'h3);
   endproperty
   property p_in1_ack;
      s_in_ep1 |=> hs_valid && hs_code == 2'h0;
   endproperty
   property p_setup_ack;
      tok_valid && tok_pid == 2'h2 |=> hs_valid && hs_code == 2'h0;
   endproperty
   property p_stall_cause;
      hs_valid && hs_code == 2'h2 |->
         $past(tok_pid) == 2'h0 && $past(tok_ep) == 2'h0;
   endproperty
   property p_wake_k;
      dev_oe |-> dev_line == 2'h2 && line == 2'h2;
   endproperty
   property p_release;
      $fell(dev_oe) |-> line != 2'h2;
   endproperty

   a_resume_len: assert property (p_resume_len)
      else $error("host K length wrong");
   a_se0_len: assert property (p_se0_len)
      else $error("host SE0 length wrong");
   a_sof_after: assert property (p_sof_after)
      else $error("no traffic after resume");
   a_in1_ack: assert property (p_in1_ack)
      else $error("IN ep1 not acknowledged");
   a_setup_ack: assert property (p_setup_ack)
      else $error("SETUP not acknowledged");
   a_stall_cause: assert property (p_stall_cause)
      else $error("STALL without OUT ep0");
   a_wake_k: assert property (p_wake_k)
      else $error("device drive not K");
   a_release: assert property (p_release)
      else $error("line still K after release");
endmodule : usbsr_link_sva
